// [rtc_pkg.sv]
// Constants, register map and helper functions for the calendar clock.
// Assumes a 32-bit APB slave with byte addresses and one register a word.
package rtc_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int NUM_FIELDS = 7;
   localparam int NUM_ALARMS = 6;
   localparam int IRQ_W = 3;
   localparam int DIV_W = 15;
   localparam int SUB_LO = 8;
   localparam int SUB_W = 7;

   // Field order shared by counters and alarm registers
   localparam int FLD_SEC = 0;
   localparam int FLD_MIN = 1;
   localparam int FLD_HOUR = 2;
   localparam int FLD_WEEK = 3;
   localparam int FLD_DATE = 4;
   localparam int FLD_MONTH = 5;
   localparam int FLD_YEAR = 6;

   localparam logic [ADDR_W-1:0] WORD_BYTES = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_SUBSEC = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_FIELD0 = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_ALARM0 = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_CTRL1 = 8'h38;
   localparam logic [ADDR_W-1:0] OFS_CTRL2 = 8'h3c;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h40;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h44;

   // Lowest legal value of each field, also its reset value (year first)
   localparam logic [NUM_FIELDS-1:0][REG_W-1:0] FIELD_MIN =
      {8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
   // Highest BCD value; the date entry is replaced by the month length
   localparam logic [NUM_FIELDS-1:0][REG_W-1:0] FIELD_MAX =
      {8'h99, 8'h12, 8'h31, 8'h06, 8'h23, 8'h59, 8'h59};

   localparam int C1_ALARM_FLAG = 0;
   localparam int C1_ALARM_IRQ_EN = 3;
   localparam int ALARM_EN_BIT = 7;

   localparam int IRQ_ALARM = 0;
   localparam int IRQ_PERIOD = 1;
   localparam int IRQ_CARRY = 2;

   localparam logic [REG_W-1:0] ROUND_UP_SEC = 8'h30;
   localparam logic [REG_W-1:0] ZERO_SEC = 8'h00;
   localparam logic [3:0] BCD_NINE = 4'h9;
   localparam logic [DIV_W-1:0] DIV_ALL_ONES = 15'h7fff;

   localparam logic [2:0] PER_NONE = 3'h0;
   localparam logic [2:0] PER_2S = 3'h7;

   typedef struct packed {
      logic per_flag;
      logic [2:0] period_select;
      logic oscillator_enable;
      logic half_minute_round;
      logic divider_reset;
      logic run;
   } ctrl2_t;

   localparam ctrl2_t CTRL2_RESET = '{per_flag: 1'b0, period_select: 3'h0,
      oscillator_enable: 1'b1, half_minute_round: 1'b0,
      divider_reset: 1'b0, run: 1'b1};

   // Leap years of a two-digit BCD year: multiples of four
   function automatic logic is_leap(input logic [REG_W-1:0] yr);
      logic tens_odd;
      tens_odd = yr[4];
      is_leap = tens_odd ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                         : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                            yr[3:0] == 4'h8);
   endfunction : is_leap

   function automatic logic [REG_W-1:0] days_in_month(
      input logic [REG_W-1:0] mon, input logic [REG_W-1:0] yr);
      unique case (mon)
         8'h02: days_in_month = is_leap(yr) ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: days_in_month = 8'h30;
         default: days_in_month = 8'h31;
      endcase
   endfunction : days_in_month

   // Divider bits that must all be one at the end of each interval
   function automatic logic [DIV_W-1:0] period_mask(input logic [2:0] sel);
      unique case (sel)
         3'h1: period_mask = 15'h007f;
         3'h2: period_mask = 15'h01ff;
         3'h3: period_mask = 15'h07ff;
         3'h4: period_mask = 15'h1fff;
         3'h5: period_mask = 15'h3fff;
         default: period_mask = DIV_ALL_ONES;
      endcase
   endfunction : period_mask

endpackage : rtc_pkg

// [bcd_field_counter.sv]
// One BCD calendar field: counts from a low to a high value and wraps.
// Load takes priority over wrap and increment.
`timescale 1ns/10ps
module bcd_field_counter #(
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic inc,
   input wire logic load,
   input wire logic [7:0] load_val,
   input wire logic [7:0] min_val,
   input wire logic [7:0] max_val,
   output logic [7:0] value,
   output logic wrap
);

   logic [7:0] count_ff;
   logic [7:0] nxt_count;
   logic [7:0] bumped;

   // Units roll from nine into the tens digit
   assign bumped = (count_ff[3:0] == rtc_pkg::BCD_NINE) ?
                   {count_ff[7:4] + 4'h1, 4'h0} :
                   {count_ff[7:4], count_ff[3:0] + 4'h1};
   // Greater-or-equal so an out-of-range date still wraps
   assign wrap = inc & (count_ff >= max_val);
   assign nxt_count = load ? load_val :
                      wrap ? min_val :
                      inc ? bumped : count_ff;
   assign value = count_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_ff <= RESET_VAL;
      end else if (ce) begin
         count_ff <= nxt_count;
      end
   end

endmodule : bcd_field_counter

// [rtc_core.sv]
// Calendar clock with alarm, periodic interrupt and APB register access.
// Assumes a slow crystal square wave on slow_crystal_input, far below pclk.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module rtc_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic slow_crystal_input,
   output logic irq
);

   localparam int NF = rtc_pkg::NUM_FIELDS;
   localparam int NA = rtc_pkg::NUM_ALARMS;
   localparam int RW = rtc_pkg::REG_W;

   ////////////////////////////////////////////////////////////////////////
   // Register state

   rtc_pkg::ctrl2_t ctrl2_ff;
   logic alarm_flag_ff;
   logic alarm_irq_enable_ff;
   logic [NA-1:0][RW-1:0] alarm_ff;
   logic [rtc_pkg::DIV_W-1:0] div_ff;
   logic two_sec_ff;
   logic match_prev_ff;
   logic [rtc_pkg::IRQ_W-1:0] irq_status_ff;
   logic [rtc_pkg::IRQ_W-1:0] irq_mask_ff;
   logic [RW-1:0] sec_shadow_ff;
   logic [31:0] prdata_ff;
   logic xtal_meta_ff;
   logic xtal_sync_ff;
   logic xtal_last_ff;

   ////////////////////////////////////////////////////////////////////////
   // Address decode

   logic [NF-1:0] sel_field;
   logic [NA-1:0] sel_alarm;
   logic sel_subsec;
   logic sel_ctrl1;
   logic sel_ctrl2;
   logic sel_stat;
   logic sel_mask;
   logic mapped;
   logic setup_phase;
   logic wr_access;
   logic wr_ctrl1;
   logic wr_ctrl2;
   logic wr_stat;
   logic wr_mask;
   logic [RW-1:0] wbyte;

   genvar gi;
   generate
      for (gi = 0; gi < NF; gi++) begin : g_fsel
         assign sel_field[gi] = paddr == rtc_pkg::OFS_FIELD0 +
            8'(gi) * rtc_pkg::WORD_BYTES;
      end
      for (gi = 0; gi < NA; gi++) begin : g_asel
         assign sel_alarm[gi] = paddr == rtc_pkg::OFS_ALARM0 +
            8'(gi) * rtc_pkg::WORD_BYTES;
      end
   endgenerate

   assign sel_subsec = paddr == rtc_pkg::OFS_SUBSEC;
   assign sel_ctrl1 = paddr == rtc_pkg::OFS_CTRL1;
   assign sel_ctrl2 = paddr == rtc_pkg::OFS_CTRL2;
   assign sel_stat = paddr == rtc_pkg::OFS_IRQ_STAT;
   assign sel_mask = paddr == rtc_pkg::OFS_IRQ_MASK;
   assign mapped = (|sel_field) | (|sel_alarm) | sel_subsec | sel_ctrl1 |
                   sel_ctrl2 | sel_stat | sel_mask;
   assign setup_phase = psel & ~penable;
   assign wr_access = psel & penable & pwrite & mapped;
   assign wr_ctrl1 = wr_access & sel_ctrl1;
   assign wr_ctrl2 = wr_access & sel_ctrl2;
   assign wr_stat = wr_access & sel_stat;
   assign wr_mask = wr_access & sel_mask;
   assign wbyte = pwdata[RW-1:0];

   // Zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   ////////////////////////////////////////////////////////////////////////
   // Crystal edge and prescaler

   logic xtal_tick;
   logic round_wr;
   logic div_reset_wr;
   logic div_clear;
   logic div_full;
   logic sec_tick;
   logic [rtc_pkg::DIV_W-1:0] nxt_div;

   // Only the second stage reads the first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xtal_meta_ff <= 1'b0;
         xtal_sync_ff <= 1'b0;
         xtal_last_ff <= 1'b0;
      end else if (ce) begin
         xtal_meta_ff <= slow_crystal_input;
         xtal_sync_ff <= xtal_meta_ff;
         xtal_last_ff <= xtal_sync_ff;
      end
   end

   assign xtal_tick = xtal_sync_ff & ~xtal_last_ff &
                      ctrl2_ff.oscillator_enable;
   assign round_wr = wr_ctrl2 & wbyte[2];
   assign div_reset_wr = wr_ctrl2 & wbyte[1];
   assign div_clear = round_wr | div_reset_wr;
   assign div_full = div_ff == rtc_pkg::DIV_ALL_ONES;
   assign sec_tick = xtal_tick & div_full & ~div_clear;
   assign nxt_div = div_clear ? '0 :
                    xtal_tick ? div_ff + 15'h0001 : div_ff;

   ////////////////////////////////////////////////////////////////////////
   // Calendar counters

   logic [NF-1:0][RW-1:0] count;
   logic [NF-1:0] inc;
   logic [NF-1:0] load;
   logic [NF-1:0] wrap;
   logic [NF-1:0][RW-1:0] max_val;
   logic round_up;

   assign round_up = round_wr &
      (count[rtc_pkg::FLD_SEC] >= rtc_pkg::ROUND_UP_SEC);
   assign inc[rtc_pkg::FLD_SEC] = sec_tick & ctrl2_ff.run;
   assign inc[rtc_pkg::FLD_MIN] = wrap[rtc_pkg::FLD_SEC] | round_up;
   assign inc[rtc_pkg::FLD_HOUR] = wrap[rtc_pkg::FLD_MIN];
   assign inc[rtc_pkg::FLD_WEEK] = wrap[rtc_pkg::FLD_HOUR];
   assign inc[rtc_pkg::FLD_DATE] = wrap[rtc_pkg::FLD_HOUR];
   assign inc[rtc_pkg::FLD_MONTH] = wrap[rtc_pkg::FLD_DATE];
   assign inc[rtc_pkg::FLD_YEAR] = wrap[rtc_pkg::FLD_MONTH];

   generate
      for (gi = 0; gi < NF; gi++) begin : g_cnt
         // Field writes are dropped while counting so a carry cannot tear them
         if (gi == rtc_pkg::FLD_SEC) begin : g_ld_sec
            assign load[gi] = (wr_access & sel_field[gi] & ~ctrl2_ff.run) |
                              round_wr;
         end else begin : g_ld
            assign load[gi] = wr_access & sel_field[gi] &
                              ~ctrl2_ff.run;
         end
         if (gi == rtc_pkg::FLD_DATE) begin : g_mx_date
            assign max_val[gi] = rtc_pkg::days_in_month(
               count[rtc_pkg::FLD_MONTH], count[rtc_pkg::FLD_YEAR]);
         end else begin : g_mx
            assign max_val[gi] = rtc_pkg::FIELD_MAX[gi];
         end
         bcd_field_counter #(
            .RESET_VAL(rtc_pkg::FIELD_MIN[gi])
         ) u_field (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .inc(inc[gi]),
            .load(load[gi]),
            .load_val(round_wr ? rtc_pkg::ZERO_SEC : wbyte),
            .min_val(rtc_pkg::FIELD_MIN[gi]),
            .max_val(max_val[gi]),
            .value(count[gi]),
            .wrap(wrap[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Alarm compare

   logic [NA-1:0] field_ok;
   logic [NA-1:0] field_en;
   logic alarm_match;
   logic alarm_evt;

   generate
      for (gi = 0; gi < NA; gi++) begin : g_alm
         assign field_en[gi] = alarm_ff[gi][rtc_pkg::ALARM_EN_BIT];
         assign field_ok[gi] = ~field_en[gi] |
            (alarm_ff[gi][RW-2:0] == count[gi][RW-2:0]);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               alarm_ff[gi] <= '0;
            end else if (ce && wr_access && sel_alarm[gi]) begin
               alarm_ff[gi] <= wbyte;
            end
         end
      end
   endgenerate

   // Fires once as the calendar enters the matching time
   assign alarm_match = (|field_en) & (&field_ok);
   assign alarm_evt = alarm_match & ~match_prev_ff;

   ////////////////////////////////////////////////////////////////////////
   // Periodic interval and flags

   logic per_evt;
   logic [rtc_pkg::DIV_W-1:0] per_mask;
   logic nxt_per_flag;
   logic nxt_alarm_flag;
   logic [rtc_pkg::IRQ_W-1:0] irq_set;
   logic [rtc_pkg::IRQ_W-1:0] nxt_irq_status;

   assign per_mask = rtc_pkg::period_mask(ctrl2_ff.period_select);
   assign per_evt = xtal_tick & ~div_clear &
      (ctrl2_ff.period_select != rtc_pkg::PER_NONE) &
      ((div_ff & per_mask) == per_mask) &
      ((ctrl2_ff.period_select != rtc_pkg::PER_2S) | two_sec_ff);
   // An unmasked interrupt takes the flag over; masked it waits for polling
   assign nxt_per_flag = per_evt ? 1'b1 :
      (wr_ctrl2 ? wbyte[7] : ctrl2_ff.per_flag) &
      ~irq_mask_ff[rtc_pkg::IRQ_PERIOD];
   assign nxt_alarm_flag = alarm_evt | (alarm_flag_ff &
      ~(wr_ctrl1 & ~wbyte[rtc_pkg::C1_ALARM_FLAG]));

   assign irq_set[rtc_pkg::IRQ_ALARM] = alarm_evt & alarm_irq_enable_ff;
   assign irq_set[rtc_pkg::IRQ_PERIOD] = per_evt;
   assign irq_set[rtc_pkg::IRQ_CARRY] = inc[rtc_pkg::FLD_SEC];
   // Set beats a same-cycle write-one clear
   assign nxt_irq_status = irq_set |
      (irq_status_ff & ~(wr_stat ? wbyte[rtc_pkg::IRQ_W-1:0] : '0));
   assign irq = |(irq_status_ff & irq_mask_ff);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= '0;
         two_sec_ff <= 1'b0;
         match_prev_ff <= 1'b0;
         alarm_flag_ff <= 1'b0;
         irq_status_ff <= '0;
      end else if (ce) begin
         div_ff <= nxt_div;
         two_sec_ff <= div_clear ? 1'b0 : two_sec_ff ^ (xtal_tick & div_full);
         match_prev_ff <= alarm_match;
         alarm_flag_ff <= nxt_alarm_flag;
         irq_status_ff <= nxt_irq_status;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl2_ff <= rtc_pkg::CTRL2_RESET;
         alarm_irq_enable_ff <= 1'b0;
         irq_mask_ff <= '0;
      end else if (ce) begin
         ctrl2_ff.per_flag <= nxt_per_flag;
         if (wr_ctrl2) begin
            ctrl2_ff.period_select <= wbyte[6:4];
            ctrl2_ff.oscillator_enable <= wbyte[3];
            ctrl2_ff.run <= wbyte[0];
         end
         if (wr_ctrl1) begin
            alarm_irq_enable_ff <= wbyte[rtc_pkg::C1_ALARM_IRQ_EN];
         end
         if (wr_mask) begin
            irq_mask_ff <= wbyte[rtc_pkg::IRQ_W-1:0];
         end
      end
   end

   // Seconds read path refreshes on crystal edges, at most one edge late
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_shadow_ff <= rtc_pkg::FIELD_MIN[rtc_pkg::FLD_SEC];
      end else if (ce && (xtal_tick || !ctrl2_ff.run)) begin
         sec_shadow_ff <= count[rtc_pkg::FLD_SEC];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data

   logic [NF:0][RW-1:0] fld_chain;
   logic [NA:0][RW-1:0] alm_chain;
   logic [RW-1:0] ctrl1_rd;
   logic [RW-1:0] ctrl2_rd;
   logic [RW-1:0] rd_byte;

   assign fld_chain[0] = '0;
   assign alm_chain[0] = '0;
   generate
      for (gi = 0; gi < NF; gi++) begin : g_frd
         if (gi == rtc_pkg::FLD_SEC) begin : g_s
            assign fld_chain[gi+1] = fld_chain[gi] |
               ({RW{sel_field[gi]}} & sec_shadow_ff);
         end else begin : g_o
            assign fld_chain[gi+1] = fld_chain[gi] |
               ({RW{sel_field[gi]}} & count[gi]);
         end
      end
      for (gi = 0; gi < NA; gi++) begin : g_ard
         assign alm_chain[gi+1] = alm_chain[gi] |
            ({RW{sel_alarm[gi]}} & alarm_ff[gi]);
      end
   endgenerate

   assign ctrl1_rd = {4'h0, alarm_irq_enable_ff, 2'h0, alarm_flag_ff};
   // Round and divider reset bits always read zero
   assign ctrl2_rd = {ctrl2_ff.per_flag, ctrl2_ff.period_select,
      ctrl2_ff.oscillator_enable, 2'b00, ctrl2_ff.run};
   assign rd_byte = fld_chain[NF] | alm_chain[NA] |
      ({RW{sel_subsec}} & {1'b0, div_ff[rtc_pkg::DIV_W-1:rtc_pkg::SUB_LO]}) |
      ({RW{sel_ctrl1}} & ctrl1_rd) |
      ({RW{sel_ctrl2}} & ctrl2_rd) |
      ({RW{sel_stat}} & {5'h00, irq_status_ff}) |
      ({RW{sel_mask}} & {5'h00, irq_mask_ff});

   // Captured in the setup cycle, held through the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= '0;
      end else if (ce && setup_phase) begin
         prdata_ff <= {24'h000000, rd_byte};
      end
   end
   assign prdata = prdata_ff;

endmodule : rtc_core

// [rtc_core_chk.sv]
// Checker for rtc_core: APB answers, control read-back and irq masking.
// Assumes it is bound to rtc_core and sees only that module's ports.
`timescale 1ns/10ps
module rtc_core_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic slow_crystal_input,
   input wire logic irq
);
   logic wr_acc, rd_acc, wr_c1, wr_c2, wr_msk, rd_c1, rd_c2, unmapped;
   logic [6:0] c2_ff, nxt_c2;
   logic [2:0] mask_ff, nxt_mask;
   logic af_seen_ff, nxt_af_seen, pf_seen_ff, nxt_pf_seen;

   ////////////////////////////////////////////////////////////////////////
   assign wr_acc = ce && psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign wr_c1 = wr_acc && paddr == rtc_pkg::OFS_CTRL1;
   assign wr_c2 = wr_acc && paddr == rtc_pkg::OFS_CTRL2;
   assign wr_msk = wr_acc && paddr == rtc_pkg::OFS_IRQ_MASK;
   assign rd_c1 = rd_acc && paddr == rtc_pkg::OFS_CTRL1;
   assign rd_c2 = rd_acc && paddr == rtc_pkg::OFS_CTRL2;
   assign unmapped = paddr > rtc_pkg::OFS_IRQ_MASK;
   // Round and divider reset are strobes, so they never read back
   assign nxt_c2 = wr_c2 ? pwdata[6:0] & 7'h79 : c2_ff;
   assign nxt_mask = wr_msk ? pwdata[2:0] : mask_ff;
   // A flag once seen set must hold until software writes its register, or the mask register for the periodic flag
   assign nxt_af_seen = wr_c1 ? 1'b0 : (rd_c1 && prdata[0]) || af_seen_ff;
   assign nxt_pf_seen = (wr_c2 || wr_msk) ? 1'b0 :
      (rd_c2 && prdata[7] && !mask_ff[1]) || pf_seen_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         c2_ff <= 7'h09;
         mask_ff <= 3'h0;
         af_seen_ff <= 1'b0;
         pf_seen_ff <= 1'b0;
      end else begin
         c2_ff <= nxt_c2;
         mask_ff <= nxt_mask;
         af_seen_ff <= nxt_af_seen;
         pf_seen_ff <= nxt_pf_seen;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_ready_high:
      assert property (pready) else $error("pready low");
   chk_err_decode:
      assert property ((psel && penable && paddr[1:0] == 2'h0) |->
         pslverr == unmapped) else $error("pslverr decode wrong");
   chk_err_access:
      assert property (pslverr |-> psel && penable)
         else $error("pslverr outside access");
   chk_upper_zero:
      assert property (rd_acc |-> prdata[31:8] == 24'h0)
         else $error("read data upper bits set");
   chk_unmapped_zero:
      assert property (rd_acc && unmapped |-> prdata == 32'h0)
         else $error("unmapped read not zero");
   chk_rdata_hold:
      assert property (!(psel && !penable) |=> $stable(prdata))
         else $error("read data changed outside setup");
   chk_irq_masked:
      assert property (mask_ff == 3'h0 |-> !irq)
         else $error("irq high with all masked");
   chk_ctrl2_readback:
      assert property (rd_c2 |-> prdata[6:0] == c2_ff)
         else $error("control 2 read-back wrong");
   chk_alarm_sticky:
      assert property (rd_c1 && af_seen_ff |-> prdata[0])
         else $error("alarm flag lost");
   chk_pflag_sticky:
      assert property (rd_c2 && pf_seen_ff |-> prdata[7])
         else $error("periodic flag lost");
endmodule : rtc_core_chk

// [rtc_core_tb.sv]
// Self-checking bench for rtc_core: APB traffic plus a crystal source.
// Assumes rtc_pkg and rtc_core_chk are compiled before this file.
`timescale 1ns/10ps
module rtc_core_tb;
   typedef struct packed {
      logic [31:0] val;
      logic [31:0] msk;
      logic err;
   } exp_t;
   logic pclk, presetn, ce, psel, penable, pwrite, xtal;
   logic pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] v[6];
   exp_t expq[$];
   exp_t e;
   int mismatches, total_checks, cycles, edges, stop_at, xdiv, t0, seed;
   bit xtal_on;

   rtc_core rtc_core_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .slow_crystal_input(xtal), .irq(irq));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // Crystal levels last 3 pclk, longer than the one pclk the synchroniser needs
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (xtal_on && edges != stop_at) begin
         xdiv <= (xdiv == 2) ? 0 : xdiv + 1;
         if (xdiv == 2) begin
            xtal <= ~xtal;
            edges <= edges + (xtal ? 0 : 1);
         end
      end
   end

   always @(posedge pclk) begin
      if (cycles == 100000) begin
         mismatches = mismatches + 1;
         results();
      end
   end

   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && expq.size() > 0) begin
         e = expq.pop_front();
         check(prdata & e.msk, e.val & e.msk);
         check({31'h0, pslverr}, {31'h0, e.err});
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'($urandom), d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] x,
      input logic [7:0] m = 8'hff, input logic er = 1'b0);
      expq.push_back('{{24'h0, x}, {24'hffffff, m}, er});
      xfer(1'b0, a, 8'h00);
   endtask : rd

   task automatic wait_irq(input logic lvl);
      int n;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (irq !== lvl && n < 30000);
      check({31'h0, irq}, {31'h0, lvl});
   endtask : wait_irq

   function automatic logic [7:0] fa(input int f);
      fa = rtc_pkg::OFS_FIELD0 + 8'(f) * rtc_pkg::WORD_BYTES;
   endfunction : fa

   function automatic logic [7:0] aa(input int f);
      aa = rtc_pkg::OFS_ALARM0 + 8'(f) * rtc_pkg::WORD_BYTES;
   endfunction : aa

   task automatic results;
      if (mismatches == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   ////////////////////////////////////////////////////////////////////////
   initial begin
      seed = $urandom(60);
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      xtal = 1'b0;
      stop_at = -1;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(rtc_pkg::OFS_CTRL2, 8'h09);
      rd(fa(rtc_pkg::FLD_DATE), 8'h01);
      wr(fa(rtc_pkg::FLD_SEC), 8'h45);
      rd(fa(rtc_pkg::FLD_SEC), 8'h00);
      wr(rtc_pkg::OFS_CTRL2, 8'h08);
      wr(fa(rtc_pkg::FLD_MIN), 8'h10);
      for (int s = 0; s < 2; s++) begin
         wr(fa(rtc_pkg::FLD_SEC), s ? 8'h30 : 8'h29);
         rd(fa(rtc_pkg::FLD_SEC), s ? 8'h30 : 8'h29);
         wr(rtc_pkg::OFS_CTRL2, 8'h0c);
         rd(fa(rtc_pkg::FLD_SEC), 8'h00);
         rd(fa(rtc_pkg::FLD_MIN), s ? 8'h11 : 8'h10);
         rd(rtc_pkg::OFS_CTRL2, 8'h08);
      end
      // Exactly 300 crystal edges, then the divider must show 300 / 256
      stop_at = 300;
      xtal_on = 1'b1;
      while (edges < 300) @(negedge pclk);
      repeat (6) @(posedge pclk);
      rd(rtc_pkg::OFS_SUBSEC, 8'h01);
      wr(rtc_pkg::OFS_CTRL2, 8'h02);
      rd(rtc_pkg::OFS_SUBSEC, 8'h00);
      rd(rtc_pkg::OFS_CTRL2, 8'h00);
      wr(rtc_pkg::OFS_CTRL1, 8'h08);
      wr(rtc_pkg::OFS_IRQ_MASK, 8'h01);
      for (int f = 0; f < rtc_pkg::NUM_ALARMS; f++) begin
         v[f] = 8'h01 + 8'($urandom % 6);
         wr(fa(f), v[f]);
         wr(aa(f), 8'h81 + v[f]);
         repeat (6) @(posedge pclk);
         rd(rtc_pkg::OFS_CTRL1, 8'h08);
         wr(aa(f), 8'h80 | v[f]);
         wait_irq(1'b1);
         rd(rtc_pkg::OFS_CTRL1, 8'h09);
         rd(rtc_pkg::OFS_CTRL1, 8'h09);
         wr(aa(f), v[f]);
         wr(rtc_pkg::OFS_CTRL1, 8'h08);
         wr(rtc_pkg::OFS_IRQ_STAT, 8'h01);
         wait_irq(1'b0);
         rd(rtc_pkg::OFS_CTRL1, 8'h08);
      end
      wr(rtc_pkg::OFS_CTRL1, 8'h00);
      wr(aa(rtc_pkg::FLD_MIN), 8'h81 + v[1]);
      wr(aa(rtc_pkg::FLD_SEC), 8'h80 | v[0]);
      repeat (6) @(posedge pclk);
      rd(rtc_pkg::OFS_CTRL1, 8'h00);
      wr(aa(rtc_pkg::FLD_MIN), 8'h80 | v[1]);
      repeat (6) @(posedge pclk);
      rd(rtc_pkg::OFS_CTRL1, 8'h01);
      rd(rtc_pkg::OFS_IRQ_STAT, 8'h00);
      // Interval measured between two events, free of sync latency
      wr(rtc_pkg::OFS_IRQ_MASK, 8'h02);
      stop_at = -1;
      for (int s = 1; s < 4; s++) begin
         wr(rtc_pkg::OFS_CTRL2, 8'(s << 4) | 8'h08);
         wait_irq(1'b1);
         t0 = edges;
         rd(rtc_pkg::OFS_CTRL2, 8'(s << 4) | 8'h08);
         wr(rtc_pkg::OFS_IRQ_STAT, 8'h02);
         wait_irq(1'b0);
         wait_irq(1'b1);
         check(32'(edges - t0), 32'h80 << (2 * s - 2));
         wr(rtc_pkg::OFS_IRQ_STAT, 8'h02);
      end
      // Restart and round in one write: only the read path lags
      wr(rtc_pkg::OFS_CTRL2, 8'h0d);
      repeat (12) @(posedge pclk);
      rd(fa(rtc_pkg::FLD_SEC), 8'h00);
      rd(rtc_pkg::OFS_IRQ_STAT, 8'h00, 8'h04);
      wr(rtc_pkg::OFS_IRQ_MASK, 8'h00);
      wr(rtc_pkg::OFS_CTRL2, 8'h18);
      repeat (1000) @(posedge pclk);
      rd(rtc_pkg::OFS_CTRL2, 8'h98);
      wr(rtc_pkg::OFS_CTRL2, 8'h08);
      repeat (1000) @(posedge pclk);
      rd(rtc_pkg::OFS_CTRL2, 8'h08);
      // A write made while the clock enable is low must not land
      ce <= 1'b0;
      wr(rtc_pkg::OFS_IRQ_MASK, 8'h04);
      ce <= 1'b1;
      rd(rtc_pkg::OFS_IRQ_MASK, 8'h00);
      rd(8'h48, 8'h00, 8'hff, 1'b1);
      @(posedge pclk);
      results();
   end
endmodule : rtc_core_tb

bind rtc_core rtc_core_chk rtc_core_chk_inst (.pclk(pclk),
   .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr),
   .slow_crystal_input(slow_crystal_input), .irq(irq));
